// ==== fault_log_and_protmem_regs.sv ====
// fault log base and protected memory enable registers with dma guard
// Function
// - without advanced logging support the log base register reads zero, ignores writes
// - log base bits 63:12 hold a 4KB aligned region base
// - log base bits from host address width to 63 are unimplemented and ignored
// - set log pointer command makes programmed base and size the active region
// - log base field reads back the last value written
// - size field 11:9 encodes 2^X times 4KB and reads back
// - protected memory enable register at 064h gates low and high regions
// - without low and high region support the enable register is read only
// - bit 31 is read write enable, zero after reset
// - bit 0 is read only status of actual enabling
// - with guard on and remapping off, dma into a supported region is blocked
// - with draining, in-flight translated dma drains before status shows enabled
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
module fault_log_and_protmem_regs (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // wishbone classic slave
  input wire regs_pkg::wb_req_type wb_req_in,
  output regs_pkg::wb_rsp_type wb_rsp_out,
  // capability and platform state
  input wire regs_pkg::cap_type cap_in,
  input wire logic remap_enable_in,
  input wire logic dma_inflight_in,
  // protected regions from the base and limit registers
  input wire regs_pkg::region_type low_region_in,
  input wire regs_pkg::region_type high_region_in,
  // dma request under inspection
  input wire regs_pkg::dma_req_type dma_req_in,
  // results
  output logic [63:0] active_log_base_out,
  output logic [2:0] active_log_size_out,
  output logic region_guard_status_out,
  output logic dma_block_out
);

  // whole module state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] log_lo;
    logic [31:0] log_hi;
    logic [31:0] act_lo;
    logic [31:0] act_hi;
    logic region_guard_enable;
    logic region_guard_status;
    regs_pkg::guard_state_type gst;
    logic block;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic hit_low;
  logic hit_high;
  logic access;
  logic wr;
  logic [7:0] word_adr;
  logic guard_writable;

  // byte lane merge, restricted to implemented bits
  function automatic logic [31:0] merge_word(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] sel,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < regs_pkg::BYTE_LANES; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // region compares, each gated by its own support bit
  region_hit u_low_hit (
    .region_in(low_region_in),
    .addr_in(dma_req_in.addr),
    .enable_in(cap_in.low_region_supported),
    .hit_out(hit_low)
  );

  region_hit u_high_hit (
    .region_in(high_region_in),
    .addr_in(dma_req_in.addr),
    .enable_in(cap_in.high_region_supported),
    .hit_out(hit_high)
  );

  // bus decode: one ack per request, dropped the cycle after
  always_comb begin
    access = wb_req_in.cyc && wb_req_in.stb && !s_r.ack;
    wr = access && wb_req_in.we;
    word_adr = wb_req_in.adr & regs_pkg::WORD_ALIGN_MASK;
    guard_writable = cap_in.low_region_supported || cap_in.high_region_supported;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = access;
    // read data from values before this write; unmapped reads return zero
    s_nxt.rdat = regs_pkg::WORD_RESET;
    if (access && !wb_req_in.we) begin
      case (word_adr)
        regs_pkg::OFS_LOG_LO: begin
          s_nxt.rdat = cap_in.adv_logging_supported ? s_r.log_lo : regs_pkg::WORD_RESET;
        end
        regs_pkg::OFS_LOG_HI: begin
          s_nxt.rdat = cap_in.adv_logging_supported ? s_r.log_hi : regs_pkg::WORD_RESET;
        end
        regs_pkg::OFS_GUARD: begin
          s_nxt.rdat[regs_pkg::GUARD_EN_BIT] = s_r.region_guard_enable;
          s_nxt.rdat[regs_pkg::GUARD_STAT_BIT] = s_r.region_guard_status;
        end
        regs_pkg::OFS_ACT_LO: begin
          s_nxt.rdat = s_r.act_lo;
        end
        regs_pkg::OFS_ACT_HI: begin
          s_nxt.rdat = s_r.act_hi;
        end
        default: begin
          s_nxt.rdat = regs_pkg::WORD_RESET;
        end
      endcase
    end
    // log base and size staging; mask drops bits 8:0 and bits above host width
    if (wr && cap_in.adv_logging_supported) begin
      if (word_adr == regs_pkg::OFS_LOG_LO) begin
        s_nxt.log_lo = merge_word(s_r.log_lo, wb_req_in.dat, wb_req_in.sel,
                                  regs_pkg::LOG_LO_MASK);
      end
      if (word_adr == regs_pkg::OFS_LOG_HI) begin
        s_nxt.log_hi = merge_word(s_r.log_hi, wb_req_in.dat, wb_req_in.sel,
                                  regs_pkg::LOG_HI_MASK);
      end
      // command bit is a one-shot: it latches the staged image, never stored
      if (word_adr == regs_pkg::OFS_GLOBAL_CMD && wb_req_in.sel[0]
          && wb_req_in.dat[regs_pkg::SET_LOG_PTR_BIT]) begin
        s_nxt.act_lo = s_r.log_lo;
        s_nxt.act_hi = s_r.log_hi;
      end
    end
    // guard enable; read only when no region is supported
    if (wr && guard_writable && word_adr == regs_pkg::OFS_GUARD && wb_req_in.sel[3]) begin
      s_nxt.region_guard_enable = wb_req_in.dat[regs_pkg::GUARD_EN_BIT];
    end
    // status follows enable, but with draining supported only after in-flight translated dma drains
    case (s_r.gst)
      regs_pkg::GUARD_OFF: begin
        s_nxt.region_guard_status = 1'b0;
        if (s_r.region_guard_enable) begin
          s_nxt.gst = regs_pkg::GUARD_DRAIN;
        end
      end
      regs_pkg::GUARD_DRAIN: begin
        if (!s_r.region_guard_enable) begin
          s_nxt.gst = regs_pkg::GUARD_OFF;
        end else if (!(cap_in.drain_supported && dma_inflight_in)) begin
          s_nxt.gst = regs_pkg::GUARD_ON;
          s_nxt.region_guard_status = 1'b1;
        end
      end
      regs_pkg::GUARD_ON: begin
        if (!s_r.region_guard_enable) begin
          s_nxt.gst = regs_pkg::GUARD_OFF;
          s_nxt.region_guard_status = 1'b0;
        end
      end
      default: begin
        s_nxt.gst = regs_pkg::GUARD_OFF;
        s_nxt.region_guard_status = 1'b0;
      end
    endcase
    // blocking only once status shows enabled; translated requests blocked even with remapping on
    s_nxt.block = dma_req_in.valid && s_r.region_guard_status && (hit_low || hit_high)
                  && (!remap_enable_in || dma_req_in.translated);
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r.ack <= 1'b0;
      s_r.rdat <= regs_pkg::WORD_RESET;
      s_r.log_lo <= regs_pkg::WORD_RESET;
      s_r.log_hi <= regs_pkg::WORD_RESET;
      s_r.act_lo <= regs_pkg::WORD_RESET;
      s_r.act_hi <= regs_pkg::WORD_RESET;
      s_r.region_guard_enable <= regs_pkg::GUARD_EN_RESET;
      s_r.region_guard_status <= 1'b0;
      s_r.gst <= regs_pkg::GUARD_OFF;
      s_r.block <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign wb_rsp_out.ack = s_r.ack;
  assign wb_rsp_out.dat = s_r.rdat;
  assign active_log_base_out = {s_r.act_hi, s_r.act_lo[31:regs_pkg::LOG_BASE_LSB],
                                {regs_pkg::LOG_BASE_LSB{1'b0}}};
  assign active_log_size_out = s_r.act_lo[regs_pkg::LOG_SIZE_MSB:regs_pkg::LOG_SIZE_LSB];
  assign region_guard_status_out = s_r.region_guard_status;
  assign dma_block_out = s_r.block;

endmodule // fault_log_and_protmem_regs

// ==== region_hit.sv ====
// address window compare for one protected memory region
`timescale 1ns/1ns
module region_hit (
  // region and address
  input wire regs_pkg::region_type region_in,
  input wire logic [63:0] addr_in,
  input wire logic enable_in,
  // result
  output logic hit_out
);

  // inclusive window; an empty window (limit below base) never hits
  always_comb begin
    hit_out = enable_in && (addr_in >= region_in.base) && (addr_in <= region_in.limit);
  end

endmodule // region_hit

// ==== regs_assertions.sv ====
// assertion checker for the fault log and region guard registers
`timescale 1ns/1ns
module regs_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // bus and platform inputs
  input wire regs_pkg::wb_req_type wb_req_in,
  input wire regs_pkg::cap_type cap_in,
  input wire logic remap_enable_in,
  input wire logic dma_inflight_in,
  input wire regs_pkg::region_type low_region_in,
  input wire regs_pkg::region_type high_region_in,
  input wire regs_pkg::dma_req_type dma_req_in,
  // block outputs
  input wire regs_pkg::wb_rsp_type wb_rsp_out,
  input wire logic [63:0] active_log_base_out,
  input wire logic [2:0] active_log_size_out,
  input wire logic region_guard_status_out,
  input wire logic dma_block_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // decode in the ack cycle, while the master still holds its request
  wire [7:0] adr = wb_req_in.adr & regs_pkg::WORD_ALIGN_MASK;
  wire rd = wb_rsp_out.ack & ~wb_req_in.we;
  wire gw = wb_rsp_out.ack & wb_req_in.we & (adr == 8'h64) & wb_req_in.sel[3]
    & (cap_in.low_region_supported | cap_in.high_region_supported);
  wire hold = cap_in.drain_supported & dma_inflight_in;
  // accepted guard writes, on and off
  sequence guard_on_s;
    gw && wb_req_in.dat[31];
  endsequence
  sequence guard_off_s;
    gw && !wb_req_in.dat[31];
  endsequence
  a_log_low_zero: assert property (rd && adr == 8'h58 |-> wb_rsp_out.dat[8:0] == 9'h0)
    else $error("log low bits not zero");
  a_log_unsup: assert property (rd && !cap_in.adv_logging_supported
    && (adr == 8'h58 || adr == 8'h5C) |-> wb_rsp_out.dat == 32'h0) else $error("log not zero");
  a_log_high_haw: assert property (rd && adr == 8'h5C
    |-> (wb_rsp_out.dat & ~regs_pkg::LOG_HI_MASK) == 32'h0) else $error("log high bits set");
  a_guard_rise: assert property (guard_on_s ##1 !hold |=> region_guard_status_out)
    else $error("status did not rise");
  a_guard_fall: assert property (guard_off_s |-> ##2 !region_guard_status_out)
    else $error("status did not fall");
  // a rise is only legal once nothing is left to drain
  a_drain_first: assert property ($rose(region_guard_status_out) |-> !$past(hold))
    else $error("status rose while draining");
  a_block_cause: assert property (dma_block_out
    |-> $past(region_guard_status_out) && $past(dma_req_in.valid)) else $error("stray block");
  a_active_hold: assert property (!$stable({active_log_base_out, active_log_size_out})
    |-> wb_rsp_out.ack && wb_req_in.we && adr == 8'h18) else $error("active log moved");
endmodule // regs_checker

bind fault_log_and_protmem_regs regs_checker chk_u (.ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in), .wb_req_in(wb_req_in), .cap_in(cap_in),
  .remap_enable_in(remap_enable_in), .dma_inflight_in(dma_inflight_in),
  .low_region_in(low_region_in), .high_region_in(high_region_in),
  .dma_req_in(dma_req_in), .wb_rsp_out(wb_rsp_out),
  .active_log_base_out(active_log_base_out), .active_log_size_out(active_log_size_out),
  .region_guard_status_out(region_guard_status_out), .dma_block_out(dma_block_out));

// ==== regs_pkg.sv ====
// shared constants and carrier types for the fault log and region guard registers
package regs_pkg;

  // host address width: log base bits at and above it are not implemented
  localparam int HOST_ADDR_WIDTH = 48;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_GLOBAL_CMD = 8'h18;
  localparam logic [7:0] OFS_LOG_LO = 8'h58;
  localparam logic [7:0] OFS_LOG_HI = 8'h5C;
  localparam logic [7:0] OFS_GUARD = 8'h64;
  localparam logic [7:0] OFS_ACT_LO = 8'h80;
  localparam logic [7:0] OFS_ACT_HI = 8'h84;
  localparam logic [7:0] WORD_ALIGN_MASK = 8'hFC;

  // field positions
  localparam int SET_LOG_PTR_BIT = 0;
  localparam int GUARD_EN_BIT = 31;
  localparam int GUARD_STAT_BIT = 0;
  localparam int LOG_SIZE_LSB = 9;
  localparam int LOG_SIZE_MSB = 11;
  localparam int LOG_BASE_LSB = 12;
  localparam int BYTE_LANES = 4;

  // implemented bits of the two log words; everything else reads zero
  localparam logic [31:0] LOG_LO_MASK = 32'hFFFF_FE00;
  localparam logic [31:0] LOG_HI_MASK = {{(64 - HOST_ADDR_WIDTH){1'b0}},
                                         {(HOST_ADDR_WIDTH - 32){1'b1}}};

  // values after reset
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic GUARD_EN_RESET = 1'b0;

  // guard sequencing states
  typedef enum logic [2:0] {
    GUARD_OFF = 3'b001,
    GUARD_DRAIN = 3'b010,
    GUARD_ON = 3'b100
  } guard_state_type;

  // wishbone classic request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  // capability bits seen by this block
  typedef struct packed {
    logic adv_logging_supported;
    logic low_region_supported;
    logic high_region_supported;
    logic drain_supported;
  } cap_type;

  // dma request under inspection
  typedef struct packed {
    logic valid;
    logic translated;
    logic [63:0] addr;
  } dma_req_type;

  // one protected region, inclusive bounds
  typedef struct packed {
    logic [63:0] base;
    logic [63:0] limit;
  } region_type;

endpackage

// ==== tb.sv ====
// self-checking bench of the fault log and region guard registers
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  regs_pkg::wb_req_type req = '0;
  regs_pkg::wb_rsp_type rsp;
  regs_pkg::cap_type cap = 4'hF;
  logic remap = 1'b0;
  logic inflight = 1'b0;
  regs_pkg::region_type low_r = {64'h0000_0000_0000_1000, 64'h0000_0000_0000_1FFF};
  regs_pkg::region_type high_r = {64'h0000_0001_0000_0000, 64'h0000_0001_0000_FFFF};
  regs_pkg::dma_req_type dma = '0;
  logic [63:0] act_base;
  logic [2:0] act_size;
  logic status;
  logic block;
  logic [63:0] eb = 64'h0;
  logic [31:0] q;
  logic [31:0] lo;
  logic [31:0] hi;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  fault_log_and_protmem_regs dut_u (.ref_clk_in(ref_clk), .resetn_in(resetn),
    .wb_req_in(req), .wb_rsp_out(rsp), .cap_in(cap), .remap_enable_in(remap),
    .dma_inflight_in(inflight), .low_region_in(low_r), .high_region_in(high_r),
    .dma_req_in(dma), .active_log_base_out(act_base), .active_log_size_out(act_size),
    .region_guard_status_out(status), .dma_block_out(block));
  always #50 ref_clk = ~ref_clk;
  // hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one classic cycle; request held until ack is seen high at a rising edge
  task wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    req <= regs_pkg::wb_req_type'{1'b1, 1'b1, we, a, s, d};
    do @(posedge ref_clk); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask
  // one dma request, judged one cycle later
  task dma_chk(input logic [63:0] a, input logic tr, input logic rm, input logic e);
    @(posedge ref_clk);
    dma <= regs_pkg::dma_req_type'{1'b1, tr, a};
    remap <= rm;
    @(negedge ref_clk);
    @(negedge ref_clk);
    `CHK(block, e)
  endtask
  // active base: high word trimmed at the host width, low twelve bits implied zero
  function logic [63:0] exp_base(input logic [31:0] l, input logic [31:0] h);
    return {h & regs_pkg::LOG_HI_MASK, l[31:12], 12'h000};
  endfunction
  initial begin
    void'($urandom(32'h1a63));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    wb(1'b0, 8'h64, 4'hF, 32'h0); `CHK(q, 32'h0)
    // staged words, all ones first, then random
    for (int i = 0; i < 6; i++) begin
      lo = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      hi = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      wb(1'b1, 8'h58, 4'hF, lo);
      wb(1'b1, 8'h5C, 4'hF, hi);
      wb(1'b0, 8'h58, 4'hF, 32'h0); `CHK(q, lo & regs_pkg::LOG_LO_MASK)
      wb(1'b0, 8'h5C, 4'hF, 32'h0); `CHK(q, hi & regs_pkg::LOG_HI_MASK)
      `CHK(act_base, eb)
      wb(1'b1, 8'h18, 4'h1, 32'h0000_0001);
      eb = exp_base(lo, hi);
      `CHK(act_base, eb)
      `CHK(act_size, lo[11:9])
    end
    // logging unsupported: reads zero, command ignored
    cap <= 4'h7;
    wb(1'b1, 8'h58, 4'hF, 32'h1234_5000);
    wb(1'b0, 8'h58, 4'hF, 32'h0); `CHK(q, 32'h0)
    wb(1'b0, 8'h5C, 4'hF, 32'h0); `CHK(q, 32'h0)
    wb(1'b1, 8'h18, 4'h1, 32'h0000_0001); `CHK(act_base, eb)
    wb(1'b0, 8'h40, 4'hF, 32'h0); `CHK(q, 32'h0)
    // low region with draining, translation still in flight
    cap <= 4'h5;
    inflight <= 1'b1;
    wb(1'b1, 8'h64, 4'h8, 32'h8000_0000);
    repeat (4) @(negedge ref_clk);
    `CHK(status, 1'b0)
    @(posedge ref_clk);
    inflight <= 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(status, 1'b1)
    wb(1'b0, 8'h64, 4'hF, 32'h0); `CHK(q, 32'h8000_0001)
    dma_chk(64'h1000, 1'b0, 1'b0, 1'b1);
    dma_chk(64'h1FFF, 1'b1, 1'b1, 1'b1);
    dma_chk(64'h2000, 1'b0, 1'b0, 1'b0);
    dma_chk(64'h1800, 1'b0, 1'b1, 1'b0);
    dma_chk(64'h0000_0001_0000_0000, 1'b0, 1'b0, 1'b0);
    // enable byte lane off: write lost
    wb(1'b1, 8'h64, 4'h7, 32'h0);
    wb(1'b0, 8'h64, 4'hF, 32'h0); `CHK(q, 32'h8000_0001)
    wb(1'b1, 8'h64, 4'hF, 32'h0);
    repeat (3) @(negedge ref_clk);
    `CHK(status, 1'b0)
    dma_chk(64'h1000, 1'b0, 1'b0, 1'b0);
    // no draining: in-flight traffic ignored, status shows two cycles after enable is set
    @(posedge ref_clk);
    cap <= 4'h4;
    inflight <= 1'b1;
    wb(1'b1, 8'h64, 4'h8, 32'h8000_0000);
    repeat (3) @(negedge ref_clk);
    `CHK(status, 1'b1)
    // no region support at all: register read only
    cap <= 4'h1;
    wb(1'b1, 8'h64, 4'hF, 32'h0);
    wb(1'b0, 8'h64, 4'hF, 32'h0); `CHK(q[31], 1'b1)
    // logging back on: the write made while unsupported left no trace
    cap <= 4'h8;
    wb(1'b0, 8'h58, 4'hF, 32'h0); `CHK(q, lo & regs_pkg::LOG_LO_MASK)
    end_of_test();
  end
endmodule // tb
